// ==== qsp_master.sv ====
// Serial bus master model for the supply command port.
// Assumes a pull-up on the status wire and the bench system clock.
`timescale 1ns/1ps
`default_nettype none

module qsp_master (
    input  wire logic i_clk_sys, // Timing reference
    input  wire logic i_wire,    // Status wire level
    output logic      o_sclk,    // Serial clock
    output logic      o_sync,    // Frame sync
    output logic      o_sdi      // Serial data
);
    localparam int HALF = 5;
    localparam int POLL = 5000;
    int now = 0;
    int last_poll [4] = '{default: -POLL};

    initial {o_sclk, o_sync, o_sdi} = 3'b000;
    always @(posedge i_clk_sys) now <= now + 1;

    task automatic half_wait();
        repeat (HALF) @(posedge i_clk_sys);
    endtask : half_wait

    ////////////////////////////////////////////////////////////////////
    // One frame; clock stands still low outside frames
    task automatic send(input logic [15:0] w, output logic [7:0] q);
        q = 8'hFF;
        if (w[15])
        begin
            while (now - last_poll[w[13:12]] < POLL) @(posedge i_clk_sys);
            last_poll[w[13:12]] = now;
        end
        @(posedge i_clk_sys);
        o_sclk <= 1'b1;
        o_sync <= 1'b1;
        o_sdi  <= ~o_sdi;
        half_wait();
        o_sclk <= 1'b0;
        half_wait();
        for (int k = 15; k >= 0; k--)
        begin
            o_sclk <= 1'b1;
            o_sync <= 1'b0;
            o_sdi  <= w[k];
            if (k < 8) q[k] = i_wire;
            half_wait();
            o_sclk <= 1'b0;
            half_wait();
        end
        o_sdi <= ~w[0];
        half_wait();
    endtask : send
endmodule : qsp_master

`default_nettype wire

// ==== qsp_pkg.sv ====
// Types shared by the quad supply serial command port.
// Assumes qsp_regs.svh sits beside it.
`include "qsp_regs.svh"

package qsp_pkg;

    typedef struct packed {
        logic       enable;
        logic       pass_through;
        logic [3:0] code;
    } qsp_chan_type;

    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] duty_stuck;
        logic [3:0] settled;
        logic       over_temp;
    } qsp_fault_type;

endpackage : qsp_pkg

// ==== qsp_port.sv ====
// Serial command decoder, channel state and status responder of the
// four-channel supply, with a classic Wishbone slave for software.
// Assumes the serial pins run well below a quarter of i_clk_sys.
//
// Notes on behaviour
// RULE_01: Init word 0x09, zero address: stagger, disable all; init here acts at any address
// RULE_02: Low nibble 0100: enable all at code
// RULE_03: Low nibble 0000: enable addressed channel at code
// RULE_04: Low nibble 1000: disable addressed channel
// RULE_05: First bit one: return channel status byte
// RULE_06: Address top bit picks bank by pin
// RULE_07: Code 0..14 regulate, code 15 pass-through
// RULE_08: Status 00 when settled, else non-zero
// RULE_09: Overcurrent per channel, over-temp all channels
// RULE_10: Sample sync and data on falling clock
// RULE_11: Sync high clears counters, then MSB
// RULE_12: Sixteen bits MSB first, command then data
// RULE_13: Read bit selects data in or out
// RULE_14: Only frame with matching bank bit acts; init frames here act whatever their bank bit
// RULE_15: Two channel bits pick one of four
// RULE_16: Only frames with own device identifier accepted
// RULE_17: Pass-through holds switch fully on
// RULE_18: Data bit 3 one disables channel
// RULE_19: Data bit 2 programs all, starts together
// RULE_20: Init bit gated with data bit 5
// RULE_21: Not ready: off, stuck duty, overcurrent, moving, hot
// RULE_22: Master allows settle delay, polls sparingly
// RULE_23: Fixed frame bit positions
// RULE_24: Init staggers low bank ramp by four
// RULE_25: Ramp sync every eighth rising serial clock
// RULE_26: Unmatched frame ignored, output stays released
`timescale 1ns/1ps
`default_nettype none
`include "qsp_regs.svh"

module qsp_port #(
    parameter logic [3:0] DEVICE_ID = 4'h6  // Arbitrary identifier value
) (
    input  wire logic                  i_clk_sys,        // System clock
    input  wire logic                  i_reset_n,        // Async reset
    input  wire logic                  i_serial_clk,     // Serial clock pin
    input  wire logic                  i_frame_sync_in,  // Frame sync pin
    input  wire logic                  i_serial_in,      // Serial data pin
    input  wire logic                  i_status_out,     // Data out pin level
    output logic                       o_status_out,     // Data out value
    output logic                       o_status_out_oe,  // Pull data out low
    input  wire logic                  i_bank_select_pin,// Bank strap pin
    input  wire qsp_pkg::qsp_fault_type i_fault,         // Analog monitors
    output qsp_pkg::qsp_chan_type      o_chan [4],       // Channel programming
    output logic                       o_ramp_sync,      // PWM ramp start
    input  wire logic                  i_wb_cyc,         // Wishbone cycle
    input  wire logic                  i_wb_stb,         // Wishbone strobe
    input  wire logic                  i_wb_we,          // Wishbone write
    input  wire logic [7:0]            i_wb_adr,         // Byte address
    input  wire logic [3:0]            i_wb_sel,         // Byte enables
    input  wire logic [31:0]           i_wb_dat,         // Write data
    output logic [31:0]                o_wb_dat,         // Read data
    output logic                       o_wb_ack          // Acknowledge
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int NSYNC = 17;
    logic [NSYNC-1:0] pins_meta;
    logic [NSYNC-1:0] pins_sync;
    logic             sclk_d;
    logic             sclk_s;
    logic             sfs_s;
    logic             sdi_s;
    logic             bank_s;
    qsp_pkg::qsp_fault_type flt_s;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pins_meta <= '0;
            pins_sync <= '0;
            sclk_d    <= 1'b0;
        end
        else
        begin
            pins_meta <= {i_serial_clk, i_frame_sync_in, i_serial_in,
                          i_bank_select_pin, i_fault};
            pins_sync <= pins_meta;
            sclk_d    <= sclk_s;
        end
    end

    assign {sclk_s, sfs_s, sdi_s, bank_s, flt_s} = pins_sync;

    logic sclk_fall;
    logic sclk_rise;
    assign sclk_fall = sclk_d & ~sclk_s;  // [RULE_10]
    assign sclk_rise = ~sclk_d & sclk_s;

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave
    logic [31:0] ctrl;
    logic [15:0] last_frame;
    logic        port_en;
    assign port_en = ctrl[`QSP_CTRL_PORT_EN];

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ctrl <= `QSP_CTRL_RESET;
        else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack
                 && i_wb_adr == `QSP_OFF_CTRL && i_wb_sel[0])
            ctrl <= {31'h0, i_wb_dat[`QSP_CTRL_PORT_EN]};
    end

    logic [7:0] stat [4];
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        case (i_wb_adr)
            `QSP_OFF_CTRL:  rd_mux = ctrl;
            `QSP_OFF_CHAN:  rd_mux = {24'h0,
                                      o_chan[3].pass_through, o_chan[2].pass_through,
                                      o_chan[1].pass_through, o_chan[0].pass_through,
                                      o_chan[3].enable, o_chan[2].enable,
                                      o_chan[1].enable, o_chan[0].enable};
            `QSP_OFF_CODES: rd_mux = {16'h0, o_chan[3].code, o_chan[2].code,
                                      o_chan[1].code, o_chan[0].code};
            `QSP_OFF_FRAME: rd_mux = {16'h0, last_frame};
            `QSP_OFF_STAT:  rd_mux = {stat[3], stat[2], stat[1], stat[0]};
            default:        rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_wb_dat <= 32'h0;
        else if (i_wb_cyc && i_wb_stb && !o_wb_ack)
            o_wb_dat <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////
    // Channel status bytes
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            stat[c] = {3'h0,
                       flt_s.over_temp,                      // [RULE_09]
                       ~flt_s.settled[c],                    // [RULE_21]
                       flt_s.overcurrent[c],                 // [RULE_09]
                       flt_s.duty_stuck[c],
                       ~o_chan[c].enable};                   // [RULE_08]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial receive and status shifter
    logic [15:0] shift;
    logic [4:0]  bit_cnt;
    logic        active;
    logic        frame_done;
    logic [7:0]  out_byte;
    logic        drive;
    logic [7:0]  cmd_now;
    logic        cmd_match;
    assign cmd_now   = {shift[6:0], sdi_s};
    assign cmd_match = cmd_now[`QSP_ID_HI-8:`QSP_ID_LO-8] == DEVICE_ID  // [RULE_16]
                       && cmd_now[`QSP_BIT_BANK-8] == bank_s;           // [RULE_06]

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            shift      <= 16'h0;
            bit_cnt    <= 5'h0;
            active     <= 1'b0;
            frame_done <= 1'b0;
        end
        else
        begin
            frame_done <= 1'b0;
            if (sclk_fall && sfs_s)
            begin
                bit_cnt <= 5'h0;                             // [RULE_11]
                active  <= port_en;
            end
            else if (sclk_fall && active)
            begin
                shift   <= {shift[14:0], sdi_s};             // [RULE_12]
                bit_cnt <= bit_cnt + 5'h1;
                if (bit_cnt == `QSP_FRAME_LAST)
                begin
                    active     <= 1'b0;
                    frame_done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            out_byte <= 8'h0;
            drive    <= 1'b0;
        end
        else if (sclk_fall && sfs_s)
            drive <= 1'b0;
        else if (sclk_fall && active)
        begin
            if (bit_cnt == `QSP_CMD_LAST)
            begin
                out_byte <= stat[cmd_now[`QSP_CH_HI-8:`QSP_CH_LO-8]];  // [RULE_05]
                drive    <= cmd_now[`QSP_BIT_READ-8] & cmd_match;      // [RULE_13]
            end
            else if (bit_cnt == `QSP_FRAME_LAST)
                drive <= 1'b0;
            else
                out_byte <= {out_byte[6:0], 1'b0};
        end
    end

    // Open drain: only ever pulls low
    assign o_status_out    = 1'b0;
    assign o_status_out_oe = drive & ~out_byte[7];                    // [RULE_26]

    ////////////////////////////////////////////////////////////////////
    // Frame decode and channel programming
    logic [7:0] dat;
    logic [1:0] ch;
    logic       id_ok;
    logic       bank_ok;
    logic       is_init;
    logic       wr_hit;
    assign dat     = shift[7:0];
    assign ch      = shift[`QSP_CH_HI:`QSP_CH_LO];                      // [RULE_15]
    assign id_ok   = shift[`QSP_ID_HI:`QSP_ID_LO] == DEVICE_ID;         // [RULE_23]
    assign bank_ok = shift[`QSP_BIT_BANK] == bank_s;                    // [RULE_14]
    assign is_init = frame_done && id_ok && !shift[`QSP_BIT_READ]
                     && dat[`QSP_BIT_INIT]
                     && (dat == `QSP_INIT_DATA || dat[`QSP_BIT_INIT_GATE]); // [RULE_20]
    assign wr_hit  = frame_done && id_ok && bank_ok && !shift[`QSP_BIT_READ];

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            last_frame <= 16'h0;
        else if (frame_done)
            last_frame <= shift;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (int c = 0; c < 4; c++)
                o_chan[c] <= '0;
        end
        else if (is_init)
        begin
            for (int c = 0; c < 4; c++)
                o_chan[c] <= '0;                                    // [RULE_01] [RULE_24]
        end
        else if (wr_hit)
        begin
            if (dat[`QSP_BIT_DISABLE])
                o_chan[ch].enable <= 1'b0;                          // [RULE_04] [RULE_18]
            else if (dat[`QSP_BIT_GLOBAL])
            begin
                for (int c = 0; c < 4; c++)
                begin
                    o_chan[c].enable       <= 1'b1;                 // [RULE_02] [RULE_19]
                    o_chan[c].code         <= dat[7:4];
                    o_chan[c].pass_through <= dat[7:4] == `QSP_CODE_PASS;
                end
            end
            else if (dat[3:0] == `QSP_NIB_ONE_ON)
            begin
                o_chan[ch].enable       <= 1'b1;                    // [RULE_03]
                o_chan[ch].code         <= dat[7:4];                // [RULE_07]
                o_chan[ch].pass_through <= dat[7:4] == `QSP_CODE_PASS; // [RULE_17]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // PWM ramp divider with bank stagger
    logic [2:0] ramp_cnt;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ramp_cnt    <= 3'h0;
            o_ramp_sync <= 1'b0;
        end
        else
        begin
            o_ramp_sync <= sclk_rise && ramp_cnt == `QSP_RAMP_LAST;  // [RULE_25]
            if (is_init)
                ramp_cnt <= bank_s ? 3'h0 : `QSP_RAMP_STAGGER;       // [RULE_24]
            else if (sclk_rise)
                ramp_cnt <= ramp_cnt + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence frame_in_s;
        frame_done && id_ok && bank_ok && !shift[`QSP_BIT_READ];
    endsequence

    sequence init_s;
        frame_done && is_init;
    endsequence

    property init_clears_p;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        init_s |=> !o_chan[0].enable && !o_chan[1].enable
                   && !o_chan[2].enable && !o_chan[3].enable && o_chan[0].code == 4'h0;
    endproperty
    init_clear_a: assert property (init_clears_p) else $error("init left channel on"); // [RULE_01]

    global_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_02]
        frame_in_s ##0 (!is_init && !dat[3] && dat[2]) |=> o_chan[0].enable
        && o_chan[3].enable && o_chan[1].code == $past(dat[7:4])
        && o_chan[2].code == $past(dat[7:4])) else $error("global on failed");

    single_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_03]
        frame_in_s ##0 (!is_init && dat[3:0] == 4'h0) |=> o_chan[$past(ch)].enable
        && o_chan[$past(ch)].code == $past(dat[7:4])) else $error("channel on failed");

    single_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_04]
        frame_in_s ##0 (!is_init && dat[3]) |=> !o_chan[$past(ch)].enable)
        else $error("channel off failed");

    foreign_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_26]
        frame_done && !id_ok |=> $stable(o_chan[0]) && $stable(o_chan[1])
        && $stable(o_chan[2]) && $stable(o_chan[3])) else $error("foreign frame acted");

    sync_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_11]
        sclk_fall && sfs_s |=> bit_cnt == 5'h0 && !o_status_out_oe)
        else $error("sync did not clear counter");

    hot_status_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_09]
        flt_s.over_temp |-> stat[0] != 8'h0 && stat[1] != 8'h0
        && stat[2] != 8'h0 && stat[3] != 8'h0) else $error("hot channel ready");

    ready_status_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_08]
        o_chan[0].enable && flt_s.settled[0] && !flt_s.overcurrent[0]
        && !flt_s.duty_stuck[0] && !flt_s.over_temp |-> stat[0] == 8'h0)
        else $error("settled channel not zero");

    pass_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_17]
        o_chan[1].enable && o_chan[1].code == 4'hF |-> o_chan[1].pass_through)
        else $error("pass-through not set");

    ramp_tick_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // [RULE_25]
        sclk_rise && ramp_cnt == 3'h7 |=> o_ramp_sync ##1 !o_ramp_sync)
        else $error("ramp sync missing");

endmodule : qsp_port
`default_nettype wire

// ==== qsp_regs.svh ====
// Constants for the quad supply serial command port: bus offsets,
// frame field positions, command patterns and reset values.
// Assumes inclusion by the package and the port module only.
`ifndef QSP_REGS_SVH
`define QSP_REGS_SVH

// Wishbone register byte offsets
`define QSP_OFF_CTRL      8'h00
`define QSP_OFF_CHAN      8'h04
`define QSP_OFF_CODES     8'h08
`define QSP_OFF_FRAME     8'h0C
`define QSP_OFF_STAT      8'h10

// Control register fields and reset value
`define QSP_CTRL_PORT_EN  0
`define QSP_CTRL_RESET    32'h0000_0001

// Frame field positions
`define QSP_BIT_READ      15
`define QSP_BIT_BANK      14
`define QSP_CH_HI         13
`define QSP_CH_LO         12
`define QSP_ID_HI         11
`define QSP_ID_LO         8
`define QSP_CODE_HI       7
`define QSP_CODE_LO       4
`define QSP_BIT_DISABLE   3
`define QSP_BIT_GLOBAL    2
`define QSP_BIT_INIT_GATE 5
`define QSP_BIT_INIT      0

// Command patterns
`define QSP_INIT_DATA     8'h09
`define QSP_NIB_ONE_ON    4'h0
`define QSP_CODE_PASS     4'hF
`define QSP_FRAME_LAST    5'h0F
`define QSP_CMD_LAST      5'h07

// Ramp divider and bank stagger
`define QSP_RAMP_LAST     3'h7
`define QSP_RAMP_STAGGER  3'h4

`endif

// ==== tb.sv ====
// Self-checking bench of the supply command port.
// Assumes qsp_pkg and qsp_master; the status wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [3:0] ID = 4'h6; // Arbitrary identifier value
    localparam qsp_pkg::qsp_fault_type CLEAN = '{4'h0, 4'h0, 4'hF, 1'b0};
    logic clk, rst_n, sclk, sync, serial_in, status_out, sdo_oe, wire_lvl, bank, ramp;
    logic cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  s;
    qsp_pkg::qsp_fault_type fault;
    qsp_pkg::qsp_chan_type  chan [4];
    int fails = 0, n_compared = 0, edges = 0;
    logic ramp_arm = 1'b0, ramp_seen = 1'b0;

    assign wire_lvl = sdo_oe ? status_out : 1'b1;

    qsp_port #(.DEVICE_ID(ID)) qsp_port_i (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_serial_clk(sclk),
        .i_frame_sync_in(sync), .i_serial_in(serial_in), .i_status_out(wire_lvl),
        .o_status_out(status_out), .o_status_out_oe(sdo_oe), .i_bank_select_pin(bank),
        .i_fault(fault), .o_chan(chan), .o_ramp_sync(ramp), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack));

    qsp_master qsp_master_i (.i_clk_sys(clk), .i_wire(wire_lvl),
        .o_sclk(sclk), .o_sync(sync), .o_sdi(serial_in));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic check_chan(input int ch, input qsp_pkg::qsp_chan_type e);
        check($sformatf("chan%0d", ch), 32'(e), 32'(chan[ch]));
    endtask : check_chan

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    function automatic logic [15:0] cmd(logic r, logic bk, logic [1:0] ch, logic [7:0] d);
        return {r, bk, ch, ID, d};
    endfunction : cmd

    task automatic frame(input logic [15:0] w);
        qsp_master_i.send(w, s);
        repeat (4) @(posedge clk);
    endtask : frame

    task automatic rd_stat(input logic [1:0] ch, input logic [7:0] e);
        frame(cmd(1'b1, 1'b0, ch, 8'hA5));
        check("status", 32'(e), 32'(s));
    endtask : rd_stat

    // Ramp start spacing in serial clock rising edges
    always @(posedge sclk) edges++;
    always @(posedge clk)
    begin
        if (ramp === 1'b1)
        begin
            if (ramp_arm && ramp_seen) check("ramp gap", 32'h8, 32'(edges));
            ramp_seen = ramp_arm;
            edges = 0;
        end
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, cyc, stb, we, bank} = 5'h00;
        adr = 8'h00;
        wdat = 32'h0;
        fault = CLEAN;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, 8'h00, 32'h0); check("ctrl", 32'h1, q);
        wb(1'b1, 8'h04, 32'hFF); wb(1'b0, 8'h04, 32'h0); check("chan ro", 32'h0, q);
        wb(1'b0, 8'h14, 32'h0); check("unmapped", 32'h0, q);
        frame(cmd(1'b0, 1'b0, 2'd0, 8'h09));
        for (int i = 0; i < 4; i++) check_chan(i, '0);
        for (int i = 0; i < 4; i++) frame(cmd(1'b0, 1'b0, 2'(i), {4'(i + 3), 4'h0}));
        for (int i = 0; i < 4; i++) check_chan(i, {2'b10, 4'(i + 3)});
        wb(1'b0, 8'h08, 32'h0); check("codes", 32'h6543, q);
        ramp_arm = 1'b1;
        rd_stat(2'd0, 8'h00);
        fault <= '{4'h2, 4'h0, 4'hF, 1'b0};
        rd_stat(2'd1, 8'h04);
        rd_stat(2'd3, 8'h00);
        fault <= '{4'h0, 4'h4, 4'hF, 1'b0};
        rd_stat(2'd2, 8'h02);
        fault <= '{4'h0, 4'h0, 4'hE, 1'b0};
        rd_stat(2'd0, 8'h08);
        fault <= '{4'h0, 4'h0, 4'hF, 1'b1};
        repeat (6) @(posedge clk);
        wb(1'b0, 8'h10, 32'h0); check("stat", 32'h10101010, q);
        fault <= CLEAN;
        frame(cmd(1'b0, 1'b0, 2'd2, 8'h58));
        check("enable2", 32'h0, 32'(chan[2].enable));
        rd_stat(2'd2, 8'h01);
        frame(cmd(1'b0, 1'b0, 2'd3, 8'hA4));
        for (int i = 0; i < 4; i++) check_chan(i, {2'b10, 4'hA});
        frame(cmd(1'b0, 1'b0, 2'd1, 8'hF0));
        check_chan(1, {2'b11, 4'hF});
        wb(1'b0, 8'h04, 32'h0); check("chan", 32'h2F, q);
        wb(1'b0, 8'h0C, 32'h0); check("frame", 32'(cmd(1'b0, 1'b0, 2'd1, 8'hF0)), q);
        frame(cmd(1'b0, 1'b0, 2'd0, 8'h01));
        check_chan(0, {2'b10, 4'hA});
        frame({4'h0, ID ^ 4'h1, 8'h30});
        check_chan(0, {2'b10, 4'hA});
        qsp_master_i.send({4'h8, ID ^ 4'h1, 8'h00}, s);
        check("released", 32'hFF, 32'(s));
        bank <= 1'b1;
        frame(cmd(1'b0, 1'b0, 2'd0, 8'h70));
        check_chan(0, {2'b10, 4'hA});
        frame(cmd(1'b0, 1'b1, 2'd0, 8'h70));
        check_chan(0, {2'b10, 4'h7});
        wb(1'b1, 8'h00, 32'h0);
        frame(cmd(1'b0, 1'b1, 2'd0, 8'h20));
        check_chan(0, {2'b10, 4'h7});
        wb(1'b1, 8'h00, 32'h1);
        ramp_arm = 1'b0;
        frame(cmd(1'b0, 1'b0, 2'd2, 8'h21));
        edges = 0;
        ramp_seen = 1'b1; // High bank restarts count at zero
        ramp_arm = 1'b1;
        for (int i = 0; i < 4; i++) check_chan(i, '0);
        frame(cmd(1'b0, 1'b1, 2'd0, 8'h80));
        check_chan(0, {2'b10, 4'h8});
        close_out();
    end
endmodule : tb

`default_nettype wire
